// *** inc/olfm_params.svh ***
`ifndef OLFM_PARAMS_SVH
`define OLFM_PARAMS_SVH

// device clock rate
`define OLFM_CLK_MHZ 50
// deglitch time, microseconds
`define OLFM_DEGLITCH_US 100
`define OLFM_DEGLITCH_CYCLES (`OLFM_DEGLITCH_US * `OLFM_CLK_MHZ)
// passive check settling time, microseconds
`define OLFM_PASSIVE_SETTLE_US 10
`define OLFM_PASSIVE_SETTLE_CYCLES \
	(`OLFM_PASSIVE_SETTLE_US * `OLFM_CLK_MHZ)
// low-side current limit divisor in low-current mode
`define OLFM_LOW_CURRENT_OCP_DIV 4'hb
`define OLFM_NORMAL_OCP_DIV 4'h1
// configuration reset values
`define OLFM_RESPONSE_SEL_RST 1'b0
`define OLFM_REPORT_SEL_RST 1'b0
`define OLFM_CHECK_DISABLE_RST 1'b0
// default bridge count
`define OLFM_NUM_BRIDGES 8

`endif

// *** inc/olfm_pkg.sv ***
package olfm_pkg;

	typedef enum logic [1:0] {
		OLFM_PAS_IDLE   = 2'b00,
		OLFM_PAS_SETTLE = 2'b01,
		OLFM_PAS_EVAL   = 2'b10
	} olfm_passive_state_t;

endpackage : olfm_pkg

// *** testbench/olfm_host_model.sv ***
`timescale 1ns/10ps
module olfm_host_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic clear_req,
	input  wire logic fault_alert_out,
	input  wire logic fault_alert_oe_n,
	output logic      clear_fault_cmd,
	output logic      fault_alert_pin
);
	logic req_reg;

	// one clear write per request, however long the request is held
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_reg         <= 1'b0;
			clear_fault_cmd <= 1'b0;
		end else begin
			req_reg         <= clear_req;
			clear_fault_cmd <= clear_req & ~req_reg;
		end
	end

	// external pull-up holds the pin high when nobody sinks it
	assign fault_alert_pin = fault_alert_oe_n ? 1'b1 : fault_alert_out;
endmodule : olfm_host_model

// *** testbench/olfm_monitor_sva.sv ***
`timescale 1ns/10ps
module olfm_monitor_chk #(
	parameter int NUM_BRIDGES = 8
) (
	input wire logic                     clk,
	input wire logic                     reset_n,
	input wire logic                     low_current_mode,
	input wire logic [NUM_BRIDGES/2-1:0] pair_mode,
	input wire logic                     passive_check_start,
	input wire logic                     other_fault_present,
	input wire logic                     open_load_response_sel,
	input wire logic                     open_load_report_sel,
	input wire logic                     chip_status_open_load,
	input wire logic [NUM_BRIDGES-1:0]   bridge_high_side_open_flag,
	input wire logic [NUM_BRIDGES-1:0]   bridge_low_side_open_flag,
	input wire logic [NUM_BRIDGES-1:0]   hs_drive,
	input wire logic [NUM_BRIDGES-1:0]   ls_drive,
	input wire logic                     fault_alert_out,
	input wire logic                     fault_alert_oe_n,
	input wire logic [3:0]               ls_ocp_limit_div,
	input wire logic                     passive_check_busy,
	input wire logic                     passive_check_done
);
	wire [NUM_BRIDGES-1:0] hf = bridge_high_side_open_flag;
	wire [NUM_BRIDGES-1:0] lf = bridge_low_side_open_flag;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	alert_sink_only_a: assert property (fault_alert_out == 1'b0)
		else $error("alert pin driven high");
	pin_on_fault_a: assert property ($rose(chip_status_open_load) &&
		!open_load_report_sel |=> !fault_alert_oe_n) else $error("pin silent");
	pin_release_a: assert property (!$past(chip_status_open_load)
		|-> fault_alert_oe_n) else $error("pin low without fault");
	report_quiet_a: assert property (open_load_report_sel &&
		$past(open_load_report_sel) |-> fault_alert_oe_n)
		else $error("pin low while reporting off");
	summary_set_a: assert property (|{hf, lf} |-> chip_status_open_load)
		else $error("flag without summary");
	tristate_bridge_a: assert property ($rose(hf[0]) &&
		!open_load_response_sel |=> !hs_drive[0] && !ls_drive[0])
		else $error("faulted bridge still driving");
	low_ocp_div_a: assert property (low_current_mode |=>
		ls_ocp_limit_div == 4'hb) else $error("low-current divisor wrong");
	norm_ocp_div_a: assert property (!low_current_mode |=>
		ls_ocp_limit_div == 4'h1) else $error("normal divisor wrong");
	pair_single_a: assert property (pair_mode[0] |->
		!((hf[0] | lf[0]) && (hf[1] | lf[1]))) else $error("both halves set");
	passive_off_a: assert property (passive_check_busy |->
		!(|hs_drive) && !(|ls_drive)) else $error("drive during passive");
	passive_block_a: assert property (other_fault_present &&
		passive_check_start && !passive_check_busy |=> !passive_check_busy)
		else $error("passive started with fault");

	cover property ($rose(chip_status_open_load));
	cover property ($fell(chip_status_open_load));
	cover property ($rose(passive_check_done));
endmodule : olfm_monitor_chk

bind olfm_monitor olfm_monitor_chk #(.NUM_BRIDGES(NUM_BRIDGES)) i_chk (.*);

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
	localparam int NB = 2;
	localparam int DG = 4;
	logic clk = 0, reset_n = 0, cfg_write = 0, clear_req = 0;
	logic cfg_response_sel = 0, cfg_report_sel = 0, low_current_mode = 0;
	logic negative_current_en = 0, other_fault_present = 0;
	logic passive_check_start = 0;
	logic [NB-1:0] hs_enable = 0, ls_enable = 0, hs_below_level = 0;
	logic [NB-1:0] ls_below_level = 0, ls_below_low_level = 0;
	logic [NB-1:0] hs_above_neg_level = 0, ls_above_neg_level = 0;
	logic [NB-1:0] bridge_recirc = 0, passive_hs_over = 0;
	logic [NB-1:0] passive_ls_under = 0, cfg_check_disable = 0;
	logic [NB/2-1:0] pair_mode = 0;
	logic clear_fault_cmd, fault_alert_pin, open_load_response_sel;
	logic open_load_report_sel, chip_status_open_load, fault_alert_out;
	logic fault_alert_oe_n, passive_source_en, passive_check_busy;
	logic passive_check_done;
	logic [NB-1:0] bridge_open_check_disable, hs_drive, ls_drive;
	logic [NB-1:0] bridge_high_side_open_flag, bridge_low_side_open_flag;
	logic [3:0] ls_ocp_limit_div;
	wire [NB-1:0] hf = bridge_high_side_open_flag;
	wire [NB-1:0] lf = bridge_low_side_open_flag;
	wire [NB+1:0] rb = {open_load_response_sel, open_load_report_sel,
		bridge_open_check_disable};
	int n_fail = 0;
	int tests_run = 0;

	always #10 clk = ~clk;
	olfm_monitor #(.NUM_BRIDGES(NB), .DEGLITCH_CYCLES(DG),
		.SETTLE_CYCLES(2)) i_dut (.*);
	olfm_host_model i_host (.*);

	task automatic test_done();
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task automatic at(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : at

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// bounded wait for any flag to appear
	task automatic wfl();
		int i;
		for (i = 0; i < 20 && (hf | lf) === '0; i++)
			at(1);
		chk(i < 20, 8'h01);
	endtask : wfl

	task automatic rst();
		@(posedge clk);
		reset_n <= 1'b0;
		{hs_enable, ls_enable, hs_below_level, ls_below_level} <= '0;
		{ls_below_low_level, hs_above_neg_level, bridge_recirc} <= '0;
		{passive_hs_over, pair_mode, low_current_mode} <= '0;
		{negative_current_en, other_fault_present} <= '0;
		at(2);
		@(posedge clk);
		reset_n <= 1'b1;
		at(2);
	endtask : rst

	task automatic cfg(input logic r, p, input logic [NB-1:0] d);
		@(posedge clk);
		{cfg_response_sel, cfg_report_sel, cfg_check_disable} <= {r, p, d};
		cfg_write <= 1'b1;
		@(posedge clk);
		cfg_write <= 1'b0;
		at(1);
		chk(rb, {r, p, d});
	endtask : cfg

	task automatic clr();
		@(posedge clk);
		clear_req <= 1'b1;
		@(posedge clk);
		clear_req <= 1'b0;
		at(4);
	endtask : clr

	task automatic t_defaults();
		chk({rb, chip_status_open_load, fault_alert_pin}, 6'h01);
		chk(ls_ocp_limit_div, 4'h1);
		chk({hf, lf}, 4'h0);
	endtask : t_defaults

	// dips shorter than the deglitch span must never add up
	task automatic t_glitch();
		@(posedge clk);
		hs_enable <= 2'h1;
		repeat (5) begin
			@(posedge clk);
			hs_below_level <= 2'h1;
			repeat (2) @(posedge clk);
			hs_below_level <= 2'h0;
		end
		at(DG + 4);
		chk({hf, hs_drive}, 4'h1);
	endtask : t_glitch

	task automatic t_active();
		@(posedge clk);
		hs_below_level <= 2'h1;
		at(DG);
		chk(hf, 2'h0);
		wfl();
		chk({hf, lf, chip_status_open_load}, 5'h09);
		at(2);
		chk({fault_alert_pin, hs_drive}, 3'h0);
		@(posedge clk);
		hs_below_level <= 2'h0;
		at(3);
		clr();
		chk({hf, chip_status_open_load, fault_alert_pin}, 4'h1);
		chk(hs_drive, 2'h1);
	endtask : t_active

	task automatic t_hold();
		rst();
		cfg(1'b1, 1'b1, 2'h0);
		@(posedge clk);
		ls_enable <= 2'h2;
		ls_below_level <= 2'h2;
		wfl();
		at(2);
		chk({lf, hf, ls_drive}, 6'h22);
		chk({fault_alert_pin, chip_status_open_load}, 2'h3);
		clr();
		chk(lf, 2'h2);
		@(posedge clk);
		ls_below_level <= 2'h0;
		at(DG + 4);
		clr();
		chk({lf, chip_status_open_load}, 3'h0);
	endtask : t_hold

	task automatic t_disable();
		rst();
		cfg(1'b0, 1'b0, 2'h1);
		@(posedge clk);
		hs_enable <= 2'h1;
		hs_below_level <= 2'h1;
		at(DG + 12);
		chk({hf, chip_status_open_load}, 3'h0);
		// hold response keeps the bridge driving, so only the disable bit
		// can take the condition away before the clear
		cfg(1'b1, 1'b0, 2'h0);
		wfl();
		cfg(1'b1, 1'b0, 2'h1);
		clr();
		chk({hf, chip_status_open_load, hs_drive}, 5'h01);
	endtask : t_disable

	task automatic t_low();
		rst();
		@(posedge clk);
		low_current_mode <= 1'b1;
		ls_enable <= 2'h1;
		ls_below_level <= 2'h1;
		at(DG + 12);
		chk({lf, ls_ocp_limit_div}, 6'h0b);
		@(posedge clk);
		ls_below_low_level <= 2'h1;
		wfl();
		chk(lf, 2'h1);
	endtask : t_low

	task automatic t_neg();
		rst();
		@(posedge clk);
		negative_current_en <= 1'b1;
		bridge_recirc <= 2'h1;
		hs_enable <= 2'h1;
		hs_below_level <= 2'h1;
		at(DG + 12);
		chk(hf, 2'h0);
		@(posedge clk);
		hs_above_neg_level <= 2'h1;
		wfl();
		chk(hf, 2'h1);
	endtask : t_neg

	task automatic t_pair();
		rst();
		@(posedge clk);
		pair_mode <= 1'b1;
		hs_enable <= 2'h1;
		ls_enable <= 2'h2;
		at(2);
		@(posedge clk);
		hs_below_level <= 2'h1;
		ls_below_level <= 2'h2;
		wfl();
		at(3);
		chk({hf, lf}, 4'h4);
	endtask : t_pair

	// passive check is refused while another fault is present, then flags from the comparators
	task automatic t_passive();
		rst();
		@(posedge clk);
		other_fault_present <= 1'b1;
		passive_hs_over <= 2'h1;
		passive_ls_under <= 2'h2;
		passive_check_start <= 1'b1;
		@(posedge clk);
		passive_check_start <= 1'b0;
		at(2);
		chk(passive_check_busy, 1'b0);
		@(posedge clk);
		other_fault_present <= 1'b0;
		passive_check_start <= 1'b1;
		@(posedge clk);
		passive_check_start <= 1'b0;
		at(1);
		chk({passive_check_busy, passive_source_en}, 2'h3);
		for (int i = 0; i < 20 && passive_check_done !== 1'b1; i++)
			at(1);
		chk({passive_check_done, hf, lf}, 5'h16);
	endtask : t_passive

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		at(2);
		t_defaults();
		t_glitch();
		t_active();
		t_hold();
		t_disable();
		t_low();
		t_neg();
		t_pair();
		t_passive();
		test_done();
	end

	initial begin
		#100000;
		n_fail++;
		test_done();
	end
endmodule : tb

// *** verilog/olfm_deglitch.sv ***
`timescale 1ns/10ps

module olfm_deglitch #(
	parameter int CYCLES = 5000
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic cond,
	output logic      declared
);

	localparam int CW = $clog2(CYCLES + 2);
	localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

	logic [CW-1:0] count_reg;

	// restart whenever the current climbs back over the level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else if (!cond) begin
			count_reg <= '0;
		end else if (count_reg != LIMIT) begin
			count_reg <= count_reg + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			declared <= 1'b0;
		end else begin
			declared <= cond && (count_reg == LIMIT);
		end
	end

endmodule : olfm_deglitch

// *** verilog/olfm_monitor.sv ***
// Overview of operation
// - active check flags open load only after current stays below level past deglitch
// - any declared open load sets the summary status flag
// - set high-side or low-side flag matching the faulted transistor
// - declared open load pulls the alert pin low when reporting enabled
// - outputs, pin and summary recover only on clear with condition gone
// - clear works once output settled high, tri-stated or check disabled
// - detection on by default; per-bridge disable bit suppresses it
// - response select zero tri-states the faulted bridge
// - response select one keeps outputs in their previous state
// - report select decides whether the alert pin shows the fault
// - defaults: tri-state response and pin reporting
// - paired full bridge flags only the half that detects first
// - passive check never starts with other faults besides overcurrent
// - passive check only with outputs off and no other scheme active
// - low-current mode checks low side only against reduced level
// - low-current mode divides the low-side current limit by eleven
// - negative mode in recirculation flags only between both levels
`timescale 1ns/10ps
`include "olfm_params.svh"

module olfm_monitor
	import olfm_pkg::*;
#(
	parameter int NUM_BRIDGES     = `OLFM_NUM_BRIDGES,
	parameter int DEGLITCH_CYCLES = `OLFM_DEGLITCH_CYCLES,
	parameter int SETTLE_CYCLES   = `OLFM_PASSIVE_SETTLE_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic [NUM_BRIDGES-1:0]   hs_enable,
	input  wire logic [NUM_BRIDGES-1:0]   ls_enable,
	input  wire logic [NUM_BRIDGES-1:0]   hs_below_level,
	input  wire logic [NUM_BRIDGES-1:0]   ls_below_level,
	input  wire logic [NUM_BRIDGES-1:0]   ls_below_low_level,
	input  wire logic [NUM_BRIDGES-1:0]   hs_above_neg_level,
	input  wire logic [NUM_BRIDGES-1:0]   ls_above_neg_level,
	input  wire logic [NUM_BRIDGES-1:0]   bridge_recirc,
	input  wire logic [NUM_BRIDGES-1:0]   passive_hs_over,
	input  wire logic [NUM_BRIDGES-1:0]   passive_ls_under,
	input  wire logic [NUM_BRIDGES/2-1:0] pair_mode,
	input  wire logic                     cfg_write,
	input  wire logic                     cfg_response_sel,
	input  wire logic                     cfg_report_sel,
	input  wire logic [NUM_BRIDGES-1:0]   cfg_check_disable,
	input  wire logic                     low_current_mode,
	input  wire logic                     negative_current_en,
	input  wire logic                     other_fault_present,
	input  wire logic                     passive_check_start,
	input  wire logic                     clear_fault_cmd,
	output logic                          open_load_response_sel,
	output logic                          open_load_report_sel,
	output logic [NUM_BRIDGES-1:0]        bridge_open_check_disable,
	output logic                          chip_status_open_load,
	output logic [NUM_BRIDGES-1:0]        bridge_high_side_open_flag,
	output logic [NUM_BRIDGES-1:0]        bridge_low_side_open_flag,
	output logic [NUM_BRIDGES-1:0]        hs_drive,
	output logic [NUM_BRIDGES-1:0]        ls_drive,
	output logic                          fault_alert_out,
	output logic                          fault_alert_oe_n,
	output logic [3:0]                    ls_ocp_limit_div,
	output logic                          passive_source_en,
	output logic                          passive_check_busy,
	output logic                          passive_check_done
);

	localparam int N = NUM_BRIDGES;
	localparam int SW = $clog2(SETTLE_CYCLES + 1);

	generate
		if (N < 2 || (N % 2) != 0 || DEGLITCH_CYCLES < 1 ||
			SETTLE_CYCLES < 1) begin : g_bad_params
			$error("olfm_monitor: unsupported parameter values");
		end
	endgenerate

	// comparator and current-sense inputs come from the analog domain
	logic [N-1:0] hs_below_s;
	logic [N-1:0] ls_below_s;
	logic [N-1:0] ls_low_s;
	logic [N-1:0] hs_neg_s;
	logic [N-1:0] ls_neg_s;
	logic [N-1:0] recirc_s;
	logic [N-1:0] pas_hs_s;
	logic [N-1:0] pas_ls_s;

	olfm_sync #(
		.WIDTH(8 * N)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.async_in({passive_ls_under, passive_hs_over, bridge_recirc,
			ls_above_neg_level, hs_above_neg_level, ls_below_low_level,
			ls_below_level, hs_below_level}),
		.sync_out({pas_ls_s, pas_hs_s, recirc_s, ls_neg_s, hs_neg_s,
			ls_low_s, ls_below_s, hs_below_s})
	);

	// configuration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			open_load_response_sel <= `OLFM_RESPONSE_SEL_RST;
			open_load_report_sel   <= `OLFM_REPORT_SEL_RST;
			bridge_open_check_disable <= {N{`OLFM_CHECK_DISABLE_RST}};
		end else if (cfg_write) begin
			open_load_response_sel    <= cfg_response_sel;
			open_load_report_sel      <= cfg_report_sel;
			bridge_open_check_disable <= cfg_check_disable;
		end
	end

	// detection conditions
	logic [N-1:0] hs_cond;
	logic [N-1:0] ls_cond;
	logic [N-1:0] hs_decl;
	logic [N-1:0] ls_decl;
	logic [N-1:0] hs_set;
	logic [N-1:0] ls_set;
	logic [N-1:0] pas_hs_set;
	logic [N-1:0] pas_ls_set;
	logic         pas_busy;

	always_comb begin
		for (int b = 0; b < N; b++) begin
			// outside recirculation the negative gate is transparent
			hs_cond[b] = hs_drive[b] && !bridge_open_check_disable[b] &&
				!pas_busy && hs_below_s[b] &&
				(!(negative_current_en && recirc_s[b]) || hs_neg_s[b]);
			ls_cond[b] = ls_drive[b] && !bridge_open_check_disable[b] &&
				!pas_busy &&
				(low_current_mode ? ls_low_s[b] : ls_below_s[b]) &&
				(!(negative_current_en && recirc_s[b]) || ls_neg_s[b]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_deglitch
			olfm_deglitch #(
				.CYCLES(DEGLITCH_CYCLES)
			) u_hs (
				.clk     (clk),
				.reset_n (reset_n),
				.cond    (hs_cond[g]),
				.declared(hs_decl[g])
			);
			olfm_deglitch #(
				.CYCLES(DEGLITCH_CYCLES)
			) u_ls (
				.clk     (clk),
				.reset_n (reset_n),
				.cond    (ls_cond[g]),
				.declared(ls_decl[g])
			);
		end
	endgenerate

	// full-bridge pairing: a partner already flagged, or the lower bridge
	// on a tie, wins; the other half stays clean
	logic [N-1:0] raw_hs;
	logic [N-1:0] raw_ls;
	logic [N-1:0] any_flag;

	always_comb begin
		for (int b = 0; b < N; b++) begin
			raw_hs[b]   = hs_decl[b] || pas_hs_set[b];
			raw_ls[b]   = ls_decl[b] || pas_ls_set[b];
			any_flag[b] = bridge_high_side_open_flag[b] ||
				bridge_low_side_open_flag[b];
		end
		for (int k = 0; k < N / 2; k++) begin
			hs_set[2*k] = raw_hs[2*k] && !(pair_mode[k] && any_flag[2*k+1]);
			ls_set[2*k] = raw_ls[2*k] && !(pair_mode[k] && any_flag[2*k+1]);
			hs_set[2*k+1] = raw_hs[2*k+1] && !(pair_mode[k] &&
				(any_flag[2*k] || raw_hs[2*k] || raw_ls[2*k]));
			ls_set[2*k+1] = raw_ls[2*k+1] && !(pair_mode[k] &&
				(any_flag[2*k] || raw_hs[2*k] || raw_ls[2*k]));
		end
	end

	// a clear only removes a flag whose condition is gone; a new set wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bridge_high_side_open_flag <= '0;
			bridge_low_side_open_flag  <= '0;
		end else begin
			bridge_high_side_open_flag <= hs_set |
				(bridge_high_side_open_flag &
				~({N{clear_fault_cmd}} & ~hs_decl));
			bridge_low_side_open_flag <= ls_set |
				(bridge_low_side_open_flag &
				~({N{clear_fault_cmd}} & ~ls_decl));
		end
	end

	logic any_set;
	logic still_open;

	assign any_set    = |{hs_set, ls_set};
	assign still_open = |{hs_decl, ls_decl};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chip_status_open_load <= 1'b0;
		end else if (any_set) begin
			chip_status_open_load <= 1'b1;
		end else if (clear_fault_cmd && !still_open) begin
			chip_status_open_load <= 1'b0;
		end
	end

	// outputs: faulted bridge goes hi-z only under the tri-state response
	logic [N-1:0] bridge_faulted;

	always_comb begin
		for (int b = 0; b < N; b++) begin
			bridge_faulted[b] = any_flag[b] && !open_load_response_sel;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hs_drive <= '0;
			ls_drive <= '0;
		end else begin
			hs_drive <= hs_enable & ~bridge_faulted & ~{N{pas_busy}};
			ls_drive <= ls_enable & ~bridge_faulted & ~{N{pas_busy}};
		end
	end

	// open-drain alert: output level is always low, the enable decides
	assign fault_alert_out = 1'b0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_alert_oe_n <= 1'b1;
		end else begin
			fault_alert_oe_n <= !(chip_status_open_load &&
				!open_load_report_sel);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ls_ocp_limit_div <= `OLFM_NORMAL_OCP_DIV;
		end else begin
			ls_ocp_limit_div <= low_current_mode ?
				`OLFM_LOW_CURRENT_OCP_DIV : `OLFM_NORMAL_OCP_DIV;
		end
	end

	// passive check sequencer
	olfm_passive_state_t pas_state_reg;
	olfm_passive_state_t pas_state_next;
	logic [SW-1:0]       settle_reg;
	logic                pas_start_ok;

	assign pas_busy = (pas_state_reg != OLFM_PAS_IDLE);
	// mixing schemes or live outputs would corrupt the voltage reading
	assign pas_start_ok = passive_check_start && !other_fault_present &&
		!(|hs_enable) && !(|ls_enable) && !(|hs_drive) && !(|ls_drive) &&
		!low_current_mode && !negative_current_en;

	always_comb begin
		pas_state_next = pas_state_reg;
		case (pas_state_reg)
			OLFM_PAS_IDLE: begin
				if (pas_start_ok) begin
					pas_state_next = OLFM_PAS_SETTLE;
				end
			end
			OLFM_PAS_SETTLE: begin
				if (other_fault_present) begin
					pas_state_next = OLFM_PAS_IDLE;
				end else if (settle_reg == SW'(SETTLE_CYCLES - 1)) begin
					pas_state_next = OLFM_PAS_EVAL;
				end
			end
			OLFM_PAS_EVAL: begin
				pas_state_next = OLFM_PAS_IDLE;
			end
			default: begin
				pas_state_next = OLFM_PAS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pas_state_reg <= OLFM_PAS_IDLE;
		end else begin
			pas_state_reg <= pas_state_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			settle_reg <= '0;
		end else if (pas_state_reg == OLFM_PAS_SETTLE) begin
			settle_reg <= settle_reg + SW'(1);
		end else begin
			settle_reg <= '0;
		end
	end

	always_comb begin
		for (int b = 0; b < N; b++) begin
			pas_hs_set[b] = (pas_state_reg == OLFM_PAS_EVAL) &&
				!bridge_open_check_disable[b] && pas_hs_s[b];
			pas_ls_set[b] = (pas_state_reg == OLFM_PAS_EVAL) &&
				!bridge_open_check_disable[b] && pas_ls_s[b];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			passive_source_en  <= 1'b0;
			passive_check_busy <= 1'b0;
			passive_check_done <= 1'b0;
		end else begin
			passive_source_en  <= (pas_state_next == OLFM_PAS_SETTLE);
			passive_check_busy <= (pas_state_next != OLFM_PAS_IDLE);
			passive_check_done <= (pas_state_reg == OLFM_PAS_EVAL);
		end
	end

endmodule : olfm_monitor

// *** verilog/olfm_sync.sv ***
`timescale 1ns/10ps

module olfm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : olfm_sync
